// ---- mbs_server.sv ----
// frame server for read bits, write one bit and write many words
`timescale 1ns/1ps

// Operation
// - word-write reply echoes header and code, then start address and count.
// - word-write reply carries length field 6.
// - a failed request gets a nine byte frame: code plus 0x80, one code.
// - read-bits request, code 0x02, start bit address in bytes 8 and 9.
// - read-bits bytes 10 and 11 give the bit count, sizing the reply.
// - read-bits reply puts a data byte count after the code.
// - bit states packed eight per byte from byte 9; 13 bits give 2 bytes.
// - write-bit request, code 0x05, address bytes 8-9, value bytes 10-11.
// - value 0x0000 clears the bit, 0xff00 sets it.
// - write-bit reply echoes header, unit, code, address and value.
// - output bits: eight addresses per byte index, byte 2 bit 0 at 0xa010.
// - word addresses 0x0000 and 0x0001 map to the first memory words.
module mbs_server #(
    parameter int OUT_BYTES = 128,
    parameter int MW_DEPTH = 32768
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // request stream
    input wire logic i_rx_valid,
    input wire mbs_pkg::mbs_beat_t i_rx,
    output logic o_rx_ready,
    // reply stream
    output logic o_tx_valid,
    output mbs_pkg::mbs_beat_t o_tx,
    input wire logic i_tx_ready,
    // output bit image
    output logic [OUT_BYTES*8-1:0] o_output_bits
);

    localparam int OUT_BITS = OUT_BYTES * 8;
    localparam int OBW = $clog2(OUT_BITS);
    localparam int MWW = $clog2(MW_DEPTH);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] be16(input logic [7:0] hi,
                                         input logic [7:0] lo);
        be16 = {hi, lo};
    endfunction

    // checks a complete fixed part; returns the exception code or zero
    function automatic logic [7:0] check_req(input logic [7:0] fc,
                                             input logic [15:0] addr,
                                             input logic [15:0] cnt);
        int a;
        int c;
        a = int'(addr);
        c = int'(cnt);
        check_req = mbs_pkg::EXC_NONE;
        case (fc)
            mbs_pkg::FC_RD_BITS: begin
                if (c == 0 || c > OUT_BITS)
                    check_req = mbs_pkg::EXC_ILL_VAL;
                else if (addr < mbs_pkg::OUT_BIT_BASE ||
                         a - int'(mbs_pkg::OUT_BIT_BASE) + c > OUT_BITS)
                    check_req = mbs_pkg::EXC_ILL_ADDR;
            end
            mbs_pkg::FC_WR_BIT: begin
                if (cnt != mbs_pkg::COIL_OFF && cnt != mbs_pkg::COIL_ON)
                    check_req = mbs_pkg::EXC_ILL_VAL;
                else if (addr < mbs_pkg::OUT_BIT_BASE ||
                         a - int'(mbs_pkg::OUT_BIT_BASE) >= OUT_BITS)
                    check_req = mbs_pkg::EXC_ILL_ADDR;
            end
            mbs_pkg::FC_WR_WORDS: begin
                if (c == 0 || cnt > mbs_pkg::MAX_WR_WORDS)
                    check_req = mbs_pkg::EXC_ILL_VAL;
                else if (a - int'(mbs_pkg::MEM_WORD_BASE) + c > MW_DEPTH)
                    check_req = mbs_pkg::EXC_ILL_ADDR;
            end
            default: check_req = mbs_pkg::EXC_ILL_FUNC;
        endcase
    endfunction

    // ****************************************
    // state
    // ****************************************
    mbs_pkg::mbs_state_t state;
    logic [7:0] hdr [0:11];
    logic [8:0] rx_idx;
    logic [7:0] err;
    logic [7:0] next_err;
    logic [7:0] word_hi;
    logic [8:0] tx_idx;
    logic [8:0] tx_len;
    logic [8:0] next_tx_len;
    logic [15:0] mem_word [0:MW_DEPTH-1];
    logic beat;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] cnt;
    logic [16:0] nbytes;
    logic [8:0] nidx;
    logic [7:0] rb;
    logic [8:0] word_k;
    logic [15:0] bit_off;

    assign beat = i_rx_valid && o_rx_ready;
    localparam int IDX_FC_I = int'(mbs_pkg::IDX_FC);
    assign fc = hdr[IDX_FC_I];
    assign addr = be16(hdr[int'(mbs_pkg::IDX_ADDR_HI)],
                       hdr[int'(mbs_pkg::IDX_ADDR_LO)]);
    // the count low byte is taken live in the cycle it arrives
    assign cnt = (rx_idx == mbs_pkg::IDX_CNT_LO && state == mbs_pkg::ST_RX) ?
                 be16(hdr[int'(mbs_pkg::IDX_CNT_HI)], i_rx.data) :
                 be16(hdr[int'(mbs_pkg::IDX_CNT_HI)],
                      hdr[int'(mbs_pkg::IDX_CNT_LO)]);
    assign nbytes = ({1'b0, cnt} + 17'h00007) >> 3;
    assign bit_off = addr - mbs_pkg::OUT_BIT_BASE;
    assign word_k = (rx_idx - mbs_pkg::IDX_DATA - 9'h001) >> 1;

    // ****************************************
    // request checking
    // ****************************************
    always_comb begin
        int last_i;
        last_i = (fc == mbs_pkg::FC_WR_WORDS) ?
                 int'(mbs_pkg::IDX_BCNT) + 2 * int'(cnt) :
                 int'(mbs_pkg::IDX_CNT_LO);
        next_err = err;
        if (rx_idx == 9'h000)
            next_err = mbs_pkg::EXC_NONE;
        if (next_err == mbs_pkg::EXC_NONE && rx_idx == mbs_pkg::IDX_CNT_LO)
            next_err = check_req(fc, addr, cnt);
        if (next_err == mbs_pkg::EXC_NONE && fc == mbs_pkg::FC_WR_WORDS &&
            rx_idx == mbs_pkg::IDX_BCNT &&
            {cnt, 1'b0} != {9'h000, i_rx.data})
            next_err = mbs_pkg::EXC_ILL_VAL;
        // short, long or truncated frames are refused
        if (next_err == mbs_pkg::EXC_NONE && i_rx.last &&
            int'(rx_idx) != last_i)
            next_err = mbs_pkg::EXC_ILL_VAL;
    end

    always_comb begin
        if (next_err != mbs_pkg::EXC_NONE)
            next_tx_len = mbs_pkg::EXC_BYTES;
        else if (fc == mbs_pkg::FC_RD_BITS)
            next_tx_len = mbs_pkg::RSP_DATA + nbytes[8:0];
        else
            next_tx_len = mbs_pkg::HDR_BYTES;
    end

    // ****************************************
    // receive side
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rx_idx <= 9'h000;
            err <= mbs_pkg::EXC_NONE;
        end else if (beat) begin
            err <= next_err;
            if (i_rx.last)
                rx_idx <= 9'h000;
            else if (rx_idx != mbs_pkg::IDX_MAX)
                rx_idx <= rx_idx + 9'h001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (beat && rx_idx < mbs_pkg::HDR_BYTES)
            hdr[rx_idx[3:0]] <= i_rx.data;
        if (beat)
            word_hi <= i_rx.data;
    end

    // words are written as they arrive; a frame that turns bad after
    // some words have landed leaves those words written
    always_ff @(posedge i_ref_clk) begin
        if (beat && fc == mbs_pkg::FC_WR_WORDS &&
            next_err == mbs_pkg::EXC_NONE &&
            rx_idx > mbs_pkg::IDX_DATA && !rx_idx[0] &&
            {7'h00, word_k} < cnt)
            mem_word[MWW'(addr - mbs_pkg::MEM_WORD_BASE + {7'h00, word_k})]
                <= be16(word_hi, i_rx.data);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst)
            o_output_bits <= '0;
        else if (beat && i_rx.last && fc == mbs_pkg::FC_WR_BIT &&
                 next_err == mbs_pkg::EXC_NONE)
            // the value low byte is only on the bus now, so take it live
            o_output_bits[bit_off[OBW-1:0]] <=
                (cnt == mbs_pkg::COIL_ON);
    end

    // ****************************************
    // reply byte builder
    // ****************************************
    assign nidx = (state == mbs_pkg::ST_RX) ? 9'h000 : tx_idx + 9'h001;

    always_comb begin
        int k;
        int p;
        rb = 8'h00;
        p = 0;
        k = int'(nidx) - int'(mbs_pkg::RSP_DATA);
        if (nidx == mbs_pkg::IDX_LEN_HI)
            rb = 8'h00;
        else if (nidx == mbs_pkg::IDX_LEN_LO) begin
            if (err != mbs_pkg::EXC_NONE)
                rb = mbs_pkg::LEN_EXC;
            else if (fc == mbs_pkg::FC_RD_BITS)
                rb = mbs_pkg::LEN_BITS_BASE + nbytes[7:0];
            else
                rb = mbs_pkg::LEN_ECHO;
        end else if (nidx < mbs_pkg::IDX_FC)
            rb = hdr[nidx[3:0]];
        else if (nidx == mbs_pkg::IDX_FC)
            rb = (err != mbs_pkg::EXC_NONE) ?
                 (fc | mbs_pkg::EXC_FLAG) : fc;
        else if (err != mbs_pkg::EXC_NONE)
            rb = err;
        else if (fc != mbs_pkg::FC_RD_BITS)
            rb = hdr[nidx[3:0]];
        else if (nidx == mbs_pkg::IDX_ADDR_HI)
            rb = nbytes[7:0];
        else begin
            for (int i = 0; i < 8; i++) begin
                p = k * 8 + i;
                if (p < int'(cnt))
                    rb[i] = o_output_bits[OBW'(int'(bit_off) + p)];
            end
        end
    end

    // ****************************************
    // reply sequencing
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state <= mbs_pkg::ST_RX;
            o_rx_ready <= 1'b1;
            o_tx_valid <= 1'b0;
            o_tx <= '0;
            tx_idx <= 9'h000;
            tx_len <= 9'h000;
        end else begin
            unique case (state)
                mbs_pkg::ST_RX: begin
                    if (beat && i_rx.last) begin
                        state <= mbs_pkg::ST_TX;
                        o_rx_ready <= 1'b0;
                        o_tx_valid <= 1'b1;
                        o_tx.data <= rb;
                        o_tx.last <= 1'b0;
                        tx_idx <= 9'h000;
                        tx_len <= next_tx_len;
                    end
                end
                mbs_pkg::ST_TX: begin
                    if (o_tx_valid && i_tx_ready) begin
                        if (tx_idx == tx_len - 9'h001) begin
                            state <= mbs_pkg::ST_RX;
                            o_rx_ready <= 1'b1;
                            o_tx_valid <= 1'b0;
                            o_tx.last <= 1'b0;
                        end else begin
                            tx_idx <= nidx;
                            o_tx.data <= rb;
                            o_tx.last <= (nidx == tx_len - 9'h001);
                        end
                    end
                end
            endcase
        end
    end

endmodule

// ---- mbs_pkg.sv ----
// constants and carrier types for the bit and word frame server
package mbs_pkg;

    // ****************************************
    // function and exception codes
    // ****************************************
    localparam logic [7:0] FC_RD_BITS = 8'h02;
    localparam logic [7:0] FC_WR_BIT = 8'h05;
    localparam logic [7:0] FC_WR_WORDS = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VAL = 8'h03;

    // ****************************************
    // byte positions inside a frame
    // ****************************************
    localparam logic [8:0] IDX_LEN_HI = 9'h004;
    localparam logic [8:0] IDX_LEN_LO = 9'h005;
    localparam logic [8:0] IDX_FC = 9'h007;
    localparam logic [8:0] IDX_ADDR_HI = 9'h008;
    localparam logic [8:0] IDX_ADDR_LO = 9'h009;
    localparam logic [8:0] IDX_CNT_HI = 9'h00a;
    localparam logic [8:0] IDX_CNT_LO = 9'h00b;
    localparam logic [8:0] IDX_BCNT = 9'h00c;
    localparam logic [8:0] IDX_DATA = 9'h00d;
    localparam logic [8:0] RSP_DATA = 9'h009;
    localparam logic [8:0] HDR_BYTES = 9'h00c;
    localparam logic [8:0] EXC_BYTES = 9'h009;
    localparam logic [8:0] IDX_MAX = 9'h1ff;

    // ****************************************
    // field values and address map
    // ****************************************
    localparam logic [7:0] LEN_ECHO = 8'h06;
    localparam logic [7:0] LEN_EXC = 8'h03;
    localparam logic [7:0] LEN_BITS_BASE = 8'h03;
    localparam logic [15:0] COIL_OFF = 16'h0000;
    localparam logic [15:0] COIL_ON = 16'hff00;
    localparam logic [15:0] OUT_BIT_BASE = 16'ha000;
    localparam logic [15:0] MEM_WORD_BASE = 16'h0000;
    localparam logic [15:0] MAX_WR_WORDS = 16'h007b;

    typedef enum logic {
        ST_RX = 1'b0,
        ST_TX = 1'b1
    } mbs_state_t;

    // one byte of a frame with its end marker
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mbs_beat_t;

endpackage

// ---- mbs_server_properties.sv ----
// port checker for the bit and word frame server
`timescale 1ns/1ps

module mbs_server_properties #(
    parameter int OUT_BYTES = 128
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // streams
    input wire logic i_rx_valid,
    input wire mbs_pkg::mbs_beat_t i_rx,
    input wire logic o_rx_ready,
    input wire logic o_tx_valid,
    input wire mbs_pkg::mbs_beat_t o_tx,
    input wire logic i_tx_ready,
    // bit image
    input wire logic [OUT_BYTES*8-1:0] o_output_bits
);
    logic [8:0] rx_idx;
    logic [8:0] tx_idx;
    logic [7:0] b0;
    logic [7:0] fc;
    wire rx_take = i_rx_valid && o_rx_ready;
    wire tx_take = o_tx_valid && i_tx_ready;
    wire rx_end = rx_take && i_rx.last;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    // ****************************************
    // byte positions of both streams
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) rx_idx <= 9'h000;
        else if (rx_take) rx_idx <= i_rx.last ? 9'h000 : rx_idx + 9'h001;
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) tx_idx <= 9'h000;
        else if (tx_take) tx_idx <= o_tx.last ? 9'h000 : tx_idx + 9'h001;
    end
    // fc stays stale on frames shorter than eight bytes
    always_ff @(posedge i_ref_clk) begin
        if (rx_take && rx_idx == 9'h000) b0 <= i_rx.data;
        if (rx_take && rx_idx == mbs_pkg::IDX_FC) fc <= i_rx.data;
    end

    // ****************************************
    // properties
    // ****************************************
    sequence s_rx_end;
        rx_take && i_rx.last;
    endsequence
    sequence s_tx_end;
        tx_take && o_tx.last;
    endsequence

    AST_REPLY_START: assert property (s_rx_end |=> o_tx_valid && !o_rx_ready)
        else $error("reply did not start after request end");
    AST_READY_BACK: assert property (s_tx_end |=> o_rx_ready && !o_tx_valid)
        else $error("request side not reopened after reply");
    AST_ONE_WAY: assert property (o_rx_ready |-> !o_tx_valid)
        else $error("reply shown while taking requests");
    AST_HOLD: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx)) else $error("stalled byte moved");
    AST_ECHO_B0: assert property (o_tx_valid && tx_idx == 9'h000 |->
        o_tx.data == b0) else $error("first byte not echoed");
    AST_LEN_HI: assert property (o_tx_valid && tx_idx == mbs_pkg::IDX_LEN_HI
        |-> o_tx.data == 8'h00) else $error("length high byte");
    AST_LEN_LO: assert property (o_tx_valid && tx_idx == mbs_pkg::IDX_LEN_LO
        && fc != mbs_pkg::FC_RD_BITS |-> o_tx.data == mbs_pkg::LEN_ECHO ||
        o_tx.data == mbs_pkg::LEN_EXC) else $error("length field");
    AST_FC: assert property (o_tx_valid && tx_idx == mbs_pkg::IDX_FC |->
        o_tx.data == fc || o_tx.data == (fc | mbs_pkg::EXC_FLAG))
        else $error("function code not echoed");
    AST_EXC_END: assert property (tx_take && tx_idx == mbs_pkg::IDX_FC &&
        o_tx.data[7] |=> o_tx.last) else $error("exception not 9 bytes");
    AST_FIXED_LEN: assert property (o_tx_valid && o_tx.last &&
        fc != mbs_pkg::FC_RD_BITS |-> tx_idx == 9'h00b || tx_idx == 9'h008)
        else $error("reply length wrong");
    AST_BITS_AT_END: assert property (!$stable(o_output_bits) |->
        $past(rx_end)) else $error("bit image moved mid frame");
endmodule

bind mbs_server mbs_server_properties #(.OUT_BYTES(OUT_BYTES)) u_props (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_rx_valid(i_rx_valid),
    .i_rx(i_rx), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid),
    .o_tx(o_tx), .i_tx_ready(i_tx_ready), .o_output_bits(o_output_bits));

// ---- mbs_client.sv ----
// model of the remote client that sends requests and takes replies
`timescale 1ns/1ps

module mbs_client (
    // clock
    input wire logic i_ref_clk,
    // request side
    input wire logic i_rx_ready,
    output logic o_rx_valid,
    output mbs_pkg::mbs_beat_t o_rx,
    // reply side
    input wire logic i_tx_valid,
    input wire mbs_pkg::mbs_beat_t i_tx,
    output logic o_tx_ready
);
    typedef logic [7:0] mbs_bytes_t[$];
    logic hung;

    initial begin
        o_rx_valid = 1'b0;
        o_rx = '0;
        o_tx_ready = 1'b0;
        hung = 1'b0;
    end

    // frames are built high byte first by the caller
    task automatic send(input mbs_bytes_t f);
        int n;
        for (int i = 0; i < f.size(); i++) begin
            o_rx_valid <= 1'b1;
            o_rx <= '{data: f[i], last: i == f.size() - 1};
            n = 0;
            do begin
                @(posedge i_ref_clk);
                n++;
            end while (!i_rx_ready && n < 50);
            if (n >= 50) hung = 1'b1;
        end
        o_rx_valid <= 1'b0;
        // a released line must not keep showing the last byte
        o_rx <= '{data: ~f[f.size() - 1], last: 1'b0};
    endtask

    // end of reply found by its marker, length judged by the caller
    task automatic recv(output mbs_bytes_t q, input bit slow);
        bit done;
        q = {};
        done = 1'b0;
        for (int n = 0; n < 100 && !done; n++) begin
            o_tx_ready <= !slow || n[1];
            @(posedge i_ref_clk);
            if (i_tx_valid && o_tx_ready) begin
                q.push_back(i_tx.data);
                done = i_tx.last;
            end
        end
        if (!done) hung = 1'b1;
        o_tx_ready <= 1'b0;
    endtask
endmodule

// ---- mbs_server_tb.sv ----
// self-checking bench for the bit and word frame server
`timescale 1ns/1ps

module mbs_server_tb;
    typedef logic [7:0] mbs_bytes_t[$];
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_rx_valid;
    mbs_pkg::mbs_beat_t i_rx;
    logic o_rx_ready;
    logic o_tx_valid;
    mbs_pkg::mbs_beat_t o_tx;
    logic i_tx_ready;
    logic [31:0] o_output_bits;
    int num_errors = 0;
    int num_checks = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    // small image: bit addresses 0xa000 to 0xa01f
    mbs_server #(.OUT_BYTES(4), .MW_DEPTH(64)) uut (.i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst), .i_rx_valid(i_rx_valid), .i_rx(i_rx),
        .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx(o_tx),
        .i_tx_ready(i_tx_ready), .o_output_bits(o_output_bits));
    mbs_client cli (.i_ref_clk(i_ref_clk), .i_rx_ready(o_rx_ready),
        .o_rx_valid(i_rx_valid), .o_rx(i_rx), .i_tx_valid(o_tx_valid),
        .i_tx(o_tx), .o_tx_ready(i_tx_ready));

    // ****************************************
    // compares and transfers
    // ****************************************
    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic check_word(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic check_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic mbs_bytes_t fr(input logic [135:0] v, input int n);
        fr = {};
        for (int i = n - 1; i >= 0; i--) fr.push_back(v[i*8 +: 8]);
    endfunction
    task automatic xfer(input mbs_bytes_t rq, input mbs_bytes_t ex,
                        input bit slow);
        mbs_bytes_t got;
        cli.send(rq);
        cli.recv(got, slow);
        if (cli.hung) begin
            num_errors++;
            tally_and_finish();
        end else begin
            check_byte(8'(got.size()), 8'(ex.size()));
            for (int i = 0; i < ex.size(); i++) check_byte(got[i], ex[i]);
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_write_bit(input logic [15:0] a, input logic [15:0] v,
                               input bit slow);
        mbs_bytes_t f;
        f = fr({64'h0001_0000_0006_0105, a, v}, 12);
        xfer(f, f, slow);
        check_bit(o_output_bits[a[4:0]], v[15]);
    endtask
    task automatic t_read_bits;
        xfer(fr(96'h0002_0000_0006_0102_a010_000d, 12),
             fr(88'h0002_0000_0005_0102_0281_11, 11), 1'b1);
    endtask
    task automatic t_write_words;
        xfer(fr(136'h0003_0000_000b_0110_0000_0002_0401_0002_00, 17),
             fr(96'h0003_0000_0006_0110_0000_0002, 12), 1'b0);
        check_word(uut.mem_word[0], 16'h0100);
        check_word(uut.mem_word[1], 16'h0200);
    endtask
    task automatic t_exceptions;
        xfer(fr(96'h0004_0000_0006_0103_0000_0001, 12),
             fr(72'h0004_0000_0003_0183_01, 9), 1'b0);
        xfer(fr(96'h0005_0000_0006_0105_a000_1234, 12),
             fr(72'h0005_0000_0003_0185_03, 9), 1'b1);
        xfer(fr(96'h0006_0000_0006_0105_a020_ff00, 12),
             fr(72'h0006_0000_0003_0185_02, 9), 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_ref_clk);
        check_bit(|o_output_bits, 1'b0);
        t_write_bit(16'ha010, mbs_pkg::COIL_ON, 1'b0);
        t_write_bit(16'ha011, mbs_pkg::COIL_ON, 1'b1);
        t_write_bit(16'ha011, mbs_pkg::COIL_OFF, 1'b0);
        t_write_bit(16'ha017, mbs_pkg::COIL_ON, 1'b0);
        t_write_bit(16'ha018, mbs_pkg::COIL_ON, 1'b0);
        t_write_bit(16'ha01c, mbs_pkg::COIL_ON, 1'b1);
        t_read_bits();
        t_write_words();
        t_exceptions();
        tally_and_finish();
    end
endmodule
